// ### rtl/sidm_pkg.sv
// package for the sector interleave and defect map formatter
package sidm_pkg;
   // register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_FACT = 8'h04;
   localparam logic [7:0] A_GEOM = 8'h08;
   localparam logic [7:0] A_TRACK = 8'h0C;
   localparam logic [7:0] A_FLAW = 8'h10;
   localparam logic [7:0] A_TABLE = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   localparam logic [7:0] A_MAP = 8'h1C;
   localparam logic [7:0] A_LINK = 8'h20;
   localparam logic [7:0] A_ALT = 8'h24;
   localparam logic [7:0] A_DIR = 8'h28;
   // control bit positions
   localparam int unsigned B_START = 0;
   localparam int unsigned B_PACKET = 1;
   localparam int unsigned B_SPARE = 2;
   localparam int unsigned B_FMTEN = 3;
   localparam int unsigned B_RECCLR = 4;
   localparam int unsigned B_ALT = 5;
   // factor codes and id control codes
   localparam logic [7:0] F_SUPPRESS = 8'hF2;
   localparam logic [7:0] F_TABLE = 8'hF0;
   localparam logic [7:0] C_USER = 8'hFF;
   localparam logic [7:0] C_SPARE = 8'hFA;
   localparam logic [7:0] C_BAD = 8'hFB;
   localparam logic [7:0] B_FILL = 8'hFF;
   localparam logic [7:0] B_BADTRK = 8'hFE;
   localparam logic [7:0] CFG_LEVEL = 8'h01;
   // map record layout
   localparam logic [6:0] R_ENT_LO = 7'h10;
   localparam logic [6:0] R_ENT_HI = 7'h7B;
   localparam logic [6:0] R_CFG_HI = 7'h0F;
   localparam logic [6:0] ENT_BYTES = 7'h06;
   localparam logic [4:0] ENT_MAX = 5'h12;
   localparam logic [5:0] SPT_MAX = 6'h20;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WTBL = 3'b001,
      ST_CLR = 3'b010,
      ST_MARK = 3'b011,
      ST_PROBE = 3'b100,
      ST_TBL = 3'b101,
      ST_DONE = 3'b110
   } sidm_state_t;
   // ahb-lite request and response
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
      logic [31:0] hwdata;
   } sidm_ahb_req_t;
   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } sidm_ahb_rsp_t;
   // whole state of the formatter
   typedef struct packed {
      sidm_state_t st;
      logic ap_valid, ap_write;
      logic [7:0] ap_addr;
      logic [31:0] hrdata;
      logic fmt_en, packet, spare_req, alt_area;
      logic [7:0] sect_f, head_f, cyl_f;
      logic [5:0] spt, spares;
      logic [11:0] cyl, prev_cyl;
      logic [3:0] head;
      logic [31:0] flaw;
      logic [5:0] tcnt;
      logic [31:0][7:0] table_b;
      logic [4:0] map_sel;
      logic [15:0] link, tab_addr, alt_base;
      logic [7:0] k;
      logic spare_on, whole, last_ok, trk_done, rec_full, dir_ok;
      logic [4:0] pos, last;
      logic [5:0] p, free, sp_left, users;
      logic [31:0] used;
      logic [31:0][7:0] code, phys;
      logic [4:0] ent_cnt;
      logic [17:0][23:0] ent;
      logic [15:0] dir_ch;
   } sidm_st_t;
endpackage : sidm_pkg

// ### rtl/sidm_format.sv
// sector interleave assignment and defect map record builder
//
// Behaviour
// - head or cylinder factor F2 suppresses that interleave.
// - a factor counts absolute positions between successive physical numbers.
// - fix sector zero, skip k positions, number next, until track full.
// - an already used target position moves on to the next free one.
// - sector factor F0 requests one table byte per sector from host.
// - table bytes number the absolute positions in the order sent.
// - head factor places sector zero after previous track's last used sector.
// - with or without sparing, head factor zero puts sector zero right after previous track's last used sector.
// - cylinder factor places sector zero when crossing to next cylinder.
// - factors cannot change outside format mode or while formatting.
// - register style command uses only the sector factor, no sparing.
// - factory flawed sectors are marked bad and given alternates; on alternate area tracks they are only marked bad.
// - first map record sits on first flaw free alternate area track.
// - map records are 128 bytes with next link in bytes 1 and 2.
// - last record of the chain carries a zero link.
// - record holds level, factor, table address, entries, FF fill.
`timescale 1ns/1ps
`default_nettype none
module sidm_format (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire sidm_pkg::sidm_ahb_req_t ahb_req,
   output sidm_pkg::sidm_ahb_rsp_t ahb_rsp
);
   sidm_pkg::sidm_st_t r, n;
   logic [31:0] rd_val;
   logic [4:0] base;
   logic [7:0] fsel;
   logic start_assign;
   logic take;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [4:0] wrap(input logic [9:0] v, input logic [5:0] m);
      wrap = 5'(v % {4'h0, m});
   endfunction : wrap

   // one byte of the map record
   function automatic logic [7:0] rec_byte(input logic [6:0] b);
      logic [6:0] o;
      logic [4:0] e;
      logic [2:0] f;
      logic [23:0] d;
      o = b - sidm_pkg::R_ENT_LO;
      e = 5'(o / sidm_pkg::ENT_BYTES);
      f = 3'(o % sidm_pkg::ENT_BYTES);
      d = r.ent[e];
      rec_byte = 8'h00;
      if (b == 7'h00) begin
         rec_byte = sidm_pkg::CFG_LEVEL;
      end else if (b == 7'h01) begin
         rec_byte = r.link[7:0];
      end else if (b == 7'h02) begin
         rec_byte = r.link[15:8];
      end else if (b == 7'h03) begin
         rec_byte = r.sect_f;
      end else if (b == 7'h04) begin
         rec_byte = r.tab_addr[7:0];
      end else if (b == 7'h05) begin
         rec_byte = r.tab_addr[15:8];
      end else if (b <= sidm_pkg::R_CFG_HI) begin
         rec_byte = 8'h00;
      end else if (b <= sidm_pkg::R_ENT_HI && e < r.ent_cnt) begin
         case (f)
            3'h0: rec_byte = d[23:16];
            3'h1: rec_byte = d[15:8];
            3'h2: rec_byte = d[7:0];
            3'h3: rec_byte = r.alt_base[7:0];
            3'h4: rec_byte = r.alt_base[15:8];
            default: rec_byte = {3'h0, e};
         endcase
      end else begin
         rec_byte = sidm_pkg::B_FILL;
      end
   endfunction : rec_byte

   ////////////////////////////////////////////////////////////////////////
   // register read mux, sampled in the address phase
   always_comb begin
      rd_val = 32'h0000_0000;
      if (ahb_req.haddr[7]) begin
         rd_val = {rec_byte({ahb_req.haddr[6:2], 2'h3}), rec_byte({ahb_req.haddr[6:2], 2'h2}),
                   rec_byte({ahb_req.haddr[6:2], 2'h1}), rec_byte({ahb_req.haddr[6:2], 2'h0})};
      end else begin
         case ({ahb_req.haddr[7:2], 2'h0})
            sidm_pkg::A_CTRL: rd_val = {26'h0, r.alt_area, 1'b0, r.fmt_en, r.spare_req,
                                        r.packet, 1'b0};
            sidm_pkg::A_FACT: rd_val = {8'h00, r.cyl_f, r.head_f, r.sect_f};
            sidm_pkg::A_GEOM: rd_val = {18'h0, r.spares, 2'h0, r.spt};
            sidm_pkg::A_TRACK: rd_val = {16'h0, r.head, r.cyl};
            sidm_pkg::A_FLAW: rd_val = r.flaw;
            sidm_pkg::A_STAT: rd_val = {16'h0, r.tcnt, r.ent_cnt, r.rec_full, r.dir_ok,
                                        r.trk_done, r.st == sidm_pkg::ST_WTBL,
                                        r.st != sidm_pkg::ST_IDLE};
            sidm_pkg::A_MAP: rd_val = {8'h00, r.code[r.map_sel], r.phys[r.map_sel], 3'h0,
                                       r.map_sel};
            sidm_pkg::A_LINK: rd_val = {r.tab_addr, r.link};
            sidm_pkg::A_ALT: rd_val = {16'h0, r.alt_base};
            sidm_pkg::A_DIR: rd_val = {15'h0, r.dir_ok, r.dir_ch};
            default: rd_val = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // placement of sector zero from the previous track
   always_comb begin
      fsel = (r.cyl != r.prev_cyl) ? r.cyl_f : r.head_f;
      base = 5'h00;
      if (r.packet && r.last_ok && fsel != sidm_pkg::F_SUPPRESS) begin
         base = wrap(10'({5'h00, r.last} + 10'h001 + {2'h0, fsel}), r.spt);
      end
      start_assign = r.st == sidm_pkg::ST_MARK && {1'b0, r.pos} == r.spt - 6'h01
                     && r.k != sidm_pkg::F_TABLE;
   end

   ////////////////////////////////////////////////////////////////////////
   // next state: bus slave and formatter sequence
   always_comb begin
      logic [5:0] fr;
      logic [5:0] rsv;
      logic [31:0] mask;
      logic add;
      logic [7:0] add_sec;
      n = r;
      fr = r.free;
      rsv = 6'h00;
      add = 1'b0;
      add_sec = 8'h00;
      mask = (r.spt >= sidm_pkg::SPT_MAX) ? 32'hFFFF_FFFF : 32'((33'h1 << r.spt) - 33'h1);
      take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
      n.ap_valid = take;
      if (take) begin
         n.ap_write = ahb_req.hwrite;
         n.ap_addr = {ahb_req.haddr[7:2], 2'h0};
         if (!ahb_req.hwrite) begin
            n.hrdata = rd_val;
         end
      end
      // data phase writes
      if (r.ap_valid && r.ap_write) begin
         case (r.ap_addr)
            sidm_pkg::A_CTRL: begin
               if (r.st == sidm_pkg::ST_IDLE) begin
                  n.packet = ahb_req.hwdata[sidm_pkg::B_PACKET];
                  n.spare_req = ahb_req.hwdata[sidm_pkg::B_SPARE];
                  n.fmt_en = ahb_req.hwdata[sidm_pkg::B_FMTEN];
                  n.alt_area = ahb_req.hwdata[sidm_pkg::B_ALT];
                  if (ahb_req.hwdata[sidm_pkg::B_RECCLR]) begin
                     n.ent_cnt = 5'h00;
                     n.rec_full = 1'b0;
                  end
                  if (ahb_req.hwdata[sidm_pkg::B_START] && ahb_req.hwdata[sidm_pkg::B_FMTEN]
                      && r.spt != 6'h00 && r.spt <= sidm_pkg::SPT_MAX) begin
                     n.k = r.sect_f;
                     n.spare_on = ahb_req.hwdata[sidm_pkg::B_PACKET]
                                  && ahb_req.hwdata[sidm_pkg::B_SPARE];
                     n.tcnt = 6'h00;
                     n.trk_done = 1'b0;
                     n.st = (r.sect_f == sidm_pkg::F_TABLE) ? sidm_pkg::ST_WTBL
                            : sidm_pkg::ST_CLR;
                  end
               end
            end
            sidm_pkg::A_FACT: begin
               if (r.fmt_en && r.st == sidm_pkg::ST_IDLE) begin
                  n.sect_f = ahb_req.hwdata[7:0];
                  n.head_f = ahb_req.hwdata[15:8];
                  n.cyl_f = ahb_req.hwdata[23:16];
               end
            end
            sidm_pkg::A_GEOM: begin
               if (r.st == sidm_pkg::ST_IDLE) begin
                  n.spt = ahb_req.hwdata[5:0];
                  n.spares = ahb_req.hwdata[13:8];
               end
            end
            sidm_pkg::A_TRACK: begin
               if (r.st == sidm_pkg::ST_IDLE) begin
                  n.cyl = ahb_req.hwdata[11:0];
                  n.head = ahb_req.hwdata[15:12];
               end
            end
            sidm_pkg::A_FLAW: begin
               if (r.st == sidm_pkg::ST_IDLE) begin
                  n.flaw = ahb_req.hwdata;
               end
            end
            sidm_pkg::A_TABLE: begin
               if (r.st == sidm_pkg::ST_WTBL && r.tcnt < r.spt) begin
                  n.table_b[r.tcnt[4:0]] = ahb_req.hwdata[7:0];
                  n.tcnt = r.tcnt + 6'h01;
               end
            end
            sidm_pkg::A_MAP: n.map_sel = ahb_req.hwdata[4:0];
            sidm_pkg::A_LINK: begin
               n.link = ahb_req.hwdata[15:0];
               n.tab_addr = ahb_req.hwdata[31:16];
            end
            sidm_pkg::A_ALT: n.alt_base = ahb_req.hwdata[15:0];
            default: ;
         endcase
      end
      // formatter sequence
      case (r.st)
         sidm_pkg::ST_IDLE: ;
         sidm_pkg::ST_WTBL: begin
            if (r.tcnt == r.spt) begin
               n.st = sidm_pkg::ST_CLR;
            end
         end
         sidm_pkg::ST_CLR: begin
            n.used = 32'h0000_0000;
            n.code = {32{sidm_pkg::C_SPARE}};
            n.phys = {32{8'hFF}};
            n.pos = 5'h00;
            n.free = r.spt;
            n.sp_left = r.spare_on ? r.spares : 6'h00;
            n.whole = (r.flaw & mask) == mask;
            if ((r.flaw & mask) == mask && !r.alt_area) begin
               add = 1'b1;
               add_sec = sidm_pkg::B_BADTRK;
            end
            n.st = sidm_pkg::ST_MARK;
         end
         sidm_pkg::ST_MARK: begin
            if (r.flaw[r.pos]) begin
               n.used[r.pos] = 1'b1;
               n.code[r.pos] = sidm_pkg::C_BAD;
               fr = r.free - 6'h01;
               if (!r.alt_area && !r.whole) begin
                  if (r.sp_left != 6'h00) begin
                     n.sp_left = r.sp_left - 6'h01;
                  end else begin
                     add = 1'b1;
                     add_sec = {3'h0, r.pos};
                  end
               end
            end
            n.free = fr;
            n.pos = r.pos + 5'h01;
            if ({1'b0, r.pos} == r.spt - 6'h01) begin
               rsv = r.spare_on ? r.spares : 6'h00;
               n.users = (rsv >= r.spt) ? 6'h00 : r.spt - rsv;
               if (fr < n.users) begin
                  n.users = fr;
               end
               n.p = 6'h00;
               if (r.k == sidm_pkg::F_TABLE) begin
                  n.pos = 5'h00;
                  n.st = sidm_pkg::ST_TBL;
               end else begin
                  n.pos = base;
                  n.st = (n.users == 6'h00) ? sidm_pkg::ST_DONE : sidm_pkg::ST_PROBE;
               end
            end
         end
         sidm_pkg::ST_PROBE: begin
            if (r.used[r.pos]) begin
               n.pos = wrap(10'({5'h00, r.pos} + 10'h001), r.spt);
            end else begin
               n.used[r.pos] = 1'b1;
               n.code[r.pos] = sidm_pkg::C_USER;
               n.phys[r.pos] = {2'h0, r.p};
               n.last = r.pos;
               n.last_ok = 1'b1;
               n.p = r.p + 6'h01;
               n.pos = wrap(10'({5'h00, r.pos} + {2'h0, r.k} + 10'h001), r.spt);
               if (r.p + 6'h01 == r.users) begin
                  n.st = sidm_pkg::ST_DONE;
               end
            end
         end
         sidm_pkg::ST_TBL: begin
            if (!r.used[r.pos]) begin
               n.used[r.pos] = 1'b1;
               n.code[r.pos] = sidm_pkg::C_USER;
               n.phys[r.pos] = r.table_b[r.pos];
               n.last = r.pos;
               n.last_ok = 1'b1;
            end
            n.pos = r.pos + 5'h01;
            if ({1'b0, r.pos} == r.spt - 6'h01) begin
               n.st = sidm_pkg::ST_DONE;
            end
         end
         sidm_pkg::ST_DONE: begin
            n.prev_cyl = r.cyl;
            n.trk_done = 1'b1;
            if (r.alt_area && r.flaw == 32'h0000_0000 && !r.dir_ok) begin
               n.dir_ok = 1'b1;
               n.dir_ch = {r.head, r.cyl};
            end
            n.st = sidm_pkg::ST_IDLE;
         end
         default: n.st = sidm_pkg::ST_IDLE;
      endcase
      // append one map entry, record full stops further entries
      if (add && !r.rec_full) begin
         n.ent[r.ent_cnt] = {r.cyl[7:0], r.head, r.cyl[11:8], add_sec};
         n.ent_cnt = r.ent_cnt + 5'h01;
         n.rec_full = (r.ent_cnt + 5'h01) == sidm_pkg::ENT_MAX;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // bus response
   assign ahb_rsp.hreadyout = 1'b1;
   assign ahb_rsp.hresp = 1'b0;
   assign ahb_rsp.hrdata = r.hrdata;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_SUPPRESS: assert property (start_assign && r.packet && fsel == sidm_pkg::F_SUPPRESS
      |=> r.pos == 5'h00)
      else $error("suppressed factor did not put sector zero after index");
   AST_HEAD_ZERO: assert property (start_assign && r.packet && r.last_ok
      && fsel == 8'h00 && r.cyl == r.prev_cyl |=> r.pos == wrap(10'({5'h00, $past(r.last)}
      + 10'h001), r.spt))
      else $error("head factor zero misplaced sector zero");
   AST_STEP: assert property (r.st == sidm_pkg::ST_PROBE && !r.used[r.pos]
      && r.p + 6'h01 != r.users |=> r.pos == wrap(10'({5'h00, $past(r.pos)}
      + {2'h0, r.k} + 10'h001), r.spt))
      else $error("interleave step wrong");
   AST_SKIP: assert property (r.st == sidm_pkg::ST_PROBE && r.used[r.pos]
      |=> $stable(r.p) && r.pos == wrap(10'({5'h00, $past(r.pos)} + 10'h001), r.spt))
      else $error("used position not skipped to next");
   AST_ASSIGN: assert property (r.st == sidm_pkg::ST_PROBE && !r.used[r.pos]
      |=> r.used[$past(r.pos)] && r.phys[$past(r.pos)] == {2'h0, $past(r.p)})
      else $error("physical number not written at position");
   AST_TABLE: assert property (r.st == sidm_pkg::ST_TBL && !r.used[r.pos]
      |=> r.phys[$past(r.pos)] == $past(r.table_b[r.pos]))
      else $error("table byte not used in order");
   AST_TBL_WAIT: assert property (r.st == sidm_pkg::ST_WTBL && r.tcnt != r.spt
      |=> r.st == sidm_pkg::ST_WTBL)
      else $error("left table wait before all bytes came");
   AST_LOCK: assert property (r.st != sidm_pkg::ST_IDLE || !r.fmt_en
      |=> $stable({r.sect_f, r.head_f, r.cyl_f}))
      else $error("factor changed outside format mode");
   AST_REG_CMD: assert property (r.st != sidm_pkg::ST_IDLE && r.spare_on
      |-> r.packet)
      else $error("sparing on under register command");
   AST_DIR: assert property ($rose(r.dir_ok) |-> $past(r.alt_area)
      && $past(r.flaw) == 32'h0000_0000)
      else $error("record placed on flawed or user track");
   AST_FILL: assert property (take && !ahb_req.hwrite && ahb_req.haddr[7:0] == 8'hFC
      |=> ahb_rsp.hrdata == 32'hFFFF_FFFF)
      else $error("record fill bytes not FF");

   COV_TABLE: cover property (r.st == sidm_pkg::ST_TBL ##1 r.st == sidm_pkg::ST_DONE);
   COV_SKIP: cover property (r.st == sidm_pkg::ST_PROBE && r.used[r.pos]);
   COV_DIR: cover property ($rose(r.dir_ok));
   COV_ENTRY: cover property ($rose(r.rec_full));
endmodule : sidm_format
`default_nettype wire

// ### verif/sidm_host.sv
// ahb-lite master model standing in for the host processor
`timescale 1ns/1ps
`default_nettype none
module sidm_host (
   // clock
   input wire logic hclk,
   // ahb-lite master side
   input wire sidm_pkg::sidm_ahb_rsp_t rsp,
   output var sidm_pkg::sidm_ahb_req_t req
);
   // idle bus at time zero
   initial begin
      req = '0;
      req.hsize = 3'h2;
   end
   ////////////////////////////////////////////////////////////
   // wait for hready at a rising edge, bounded
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (rsp.hreadyout !== 1'b1 && n < 64);
      if (rsp.hreadyout !== 1'b1) begin
         sidm_format_bench.bad_count++;
         sidm_format_bench.tally_and_finish();
      end
   endtask : wait_rdy
   // single word write, held until hready
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      req.hsel <= 1'b1;
      req.haddr <= {24'h0, a};
      req.htrans <= 2'h2;
      req.hwrite <= 1'b1;
      wait_rdy();
      req.hsel <= 1'b0;
      req.htrans <= 2'h0;
      req.hwdata <= d;
      wait_rdy();
      req.hwdata <= ~d; // released data no longer shows the value
   endtask : wr
   // single word read, data taken at the data phase edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge hclk);
      req.hsel <= 1'b1;
      req.haddr <= {24'h0, a};
      req.htrans <= 2'h2;
      req.hwrite <= 1'b0;
      wait_rdy();
      req.hsel <= 1'b0;
      req.htrans <= 2'h0;
      req.hwdata <= ~req.hwdata;
      wait_rdy();
      d = rsp.hrdata;
   endtask : rd
endmodule : sidm_host
`default_nettype wire

// ### verif/sidm_format_bench.sv
// self-checking bench for the sector interleave and defect map formatter
`timescale 1ns/1ps
`default_nettype none
module sidm_format_bench;
   // clock, reset, bus and bookkeeping
   logic hclk;
   logic hresetn;
   sidm_pkg::sidm_ahb_req_t req_m, req;
   sidm_pkg::sidm_ahb_rsp_t rsp;
   int bad_count, check_count;
   logic [7:0] e [32];
   logic [7:0] tbl [4] = '{8'h02, 8'h00, 8'h03, 8'h01};
   int rs [5] = '{5, 6, 5, 12, 7};
   int rk [5] = '{1, 1, 0, 3, 2};
   logic [15:0] ptrk [6] = '{16'h0005, 16'h1005, 16'h2005, 16'h0006, 16'h1006, 16'h2006};
   logic [7:0] phf [6] = '{8'hF2, 8'h02, 8'h00, 8'h00, 8'hF2, 8'h00};
   logic [7:0] pcf [6] = '{8'hF2, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
   localparam logic [31:0] EN = 32'h1 << sidm_pkg::B_FMTEN;
   localparam logic [31:0] GO = 32'h1 << sidm_pkg::B_START;
   localparam logic [31:0] PK = 32'h1 << sidm_pkg::B_PACKET;
   localparam logic [31:0] AL = 32'h1 << sidm_pkg::B_ALT;
   localparam logic [31:0] SP = 32'h1 << sidm_pkg::B_SPARE;
   // bus hready is the one slave's hreadyout
   always_comb begin
      req = req_m;
      req.hready = rsp.hreadyout;
   end
   sidm_host u (.hclk(hclk), .rsp(rsp), .req(req_m));
   sidm_format DUT (.hclk(hclk), .hresetn(hresetn), .ahb_req(req), .ahb_rsp(rsp));
   // 25 MHz clock
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////
   // comparisons and verdict
   task automatic chk32(input logic [31:0] g, input logic [31:0] x, input string m);
      check_count++;
      if (g !== x) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask : chk32
   task automatic chk8(input logic [7:0] g, input logic [7:0] x, input string m);
      check_count++;
      if (g !== x) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask : chk8
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////
   // expected numbering of one track, returns last used position
   function automatic int ref_map(input int spt, input int k, input int s0);
      int pos;
      pos = s0;
      foreach (e[i]) e[i] = 8'hFF;
      for (int n = 0; n < spt; n++) begin
         if (n > 0) begin
            pos = (pos + k + 1) % spt;
            while (e[pos] !== 8'hFF) pos = (pos + 1) % spt;
         end
         e[pos] = 8'(n);
      end
      return pos;
   endfunction : ref_map
   // set up and run one track format, poll until idle
   task automatic fmt(input int spt, input logic [15:0] trk, input logic [31:0] flaw,
      input logic [23:0] fact, input logic [31:0] opt);
      logic [31:0] d;
      int n;
      u.wr(sidm_pkg::A_CTRL, EN);
      u.wr(sidm_pkg::A_GEOM, 32'(spt));
      u.wr(sidm_pkg::A_TRACK, {16'h0, trk});
      u.wr(sidm_pkg::A_FLAW, flaw);
      u.wr(sidm_pkg::A_FACT, {8'h0, fact});
      u.wr(sidm_pkg::A_CTRL, EN | opt | GO);
      if (fact[7:0] == sidm_pkg::F_TABLE) begin
         u.rd(sidm_pkg::A_STAT, d);
         chk8({7'h0, d[1]}, 8'h01, "table wanted");
         for (int i = 0; i < spt; i++) u.wr(sidm_pkg::A_TABLE, {24'h0, tbl[i]});
      end
      n = 0;
      d = 32'h1;
      while (d[0] !== 1'b0) begin
         u.rd(sidm_pkg::A_STAT, d);
         n++;
         if (n > 300) begin
            bad_count++;
            tally_and_finish();
         end
      end
   endtask : fmt
   // read back every position against e
   task automatic chk_map(input int spt);
      logic [31:0] d;
      for (int p = 0; p < spt; p++) begin
         u.wr(sidm_pkg::A_MAP, 32'(p));
         u.rd(sidm_pkg::A_MAP, d);
         chk8(d[15:8], e[p], "physical number");
      end
   endtask : chk_map
   ////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [31:0] d;
      logic [11:0] pc;
      int last;
      int s0;
      int f;
      bad_count = 0;
      check_count = 0;
      hresetn = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      u.rd(sidm_pkg::A_STAT, d);
      chk32(d, 32'h0, "status reset");
      u.rd(8'h40, d);
      chk32(d, 32'h0, "unmapped read");
      // factors stay locked outside format mode
      u.wr(sidm_pkg::A_FACT, 32'h0000_0305);
      u.rd(sidm_pkg::A_FACT, d);
      chk32(d, 32'h0, "factor locked");
      // first flawless alternate track gets the map record
      fmt(5, 16'h03A0, 32'h0, 24'h000001, AL);
      u.rd(sidm_pkg::A_STAT, d);
      chk8({7'h0, d[3]}, 8'h01, "record placed");
      u.rd(sidm_pkg::A_DIR, d);
      chk32(d, 32'h0001_03A0, "record track");
      u.rd(8'h80, d);
      chk32(d, {8'h01, 16'h0, sidm_pkg::CFG_LEVEL}, "record head");
      u.rd(8'hFC, d);
      chk32(d, 32'hFFFF_FFFF, "record fill");
      u.rd(sidm_pkg::A_LINK, d);
      chk32(d, 32'h0, "last link");
      // register command: sector factor only, sector zero at index
      for (int i = 0; i < 5; i++) begin
         fmt(rs[i], {4'(i), 12'h001}, 32'h0, {16'h0202, 8'(rk[i])}, 32'h0);
         last = ref_map(rs[i], rk[i], 0);
         chk_map(rs[i]);
      end
      // host table numbers positions in order sent
      fmt(4, 16'h0002, 32'h0, {16'h0, sidm_pkg::F_TABLE}, 32'h0);
      foreach (tbl[i]) e[i] = tbl[i];
      chk_map(4);
      // factory flaw marks a bad sector and an entry
      fmt(5, 16'h0003, 32'h4, 24'h0, 32'h0);
      u.wr(sidm_pkg::A_MAP, 32'h2);
      u.rd(sidm_pkg::A_MAP, d);
      chk8(d[23:16], sidm_pkg::C_BAD, "flawed position");
      u.rd(sidm_pkg::A_STAT, d);
      chk8({3'h0, d[9:5]}, 8'h01, "entry made");
      // packet command: head and cylinder factors place sector zero
      last = 0;
      pc = 12'h003;
      for (int i = 0; i < 6; i++) begin
         f = (ptrk[i][11:0] != pc) ? pcf[i] : phf[i];
         s0 = (f == sidm_pkg::F_SUPPRESS) ? 0 : (last + f + 1) % 5;
         fmt(5, ptrk[i], 32'h0, {pcf[i], phf[i], 8'h00}, PK);
         last = ref_map(5, 0, s0);
         chk_map(5);
         pc = ptrk[i][11:0];
      end
      // one spare per track: the next track starts on the unused spare
      fmt(32'h0105, 16'h3006, 32'h0, 24'h0, PK | SP);
      last = ref_map(5, 0, (last + 1) % 5);
      e[last] = 8'hFF;
      chk_map(5);
      fmt(5, 16'h4006, 32'h0, 24'h0, PK);
      last = ref_map(5, 0, last);
      chk_map(5);
      tally_and_finish();
   end
endmodule : sidm_format_bench
`default_nettype wire
